/* bench/sfs_bank_properties.sv */
// Bus timing and field checks of the safety status bank
`timescale 1ns/100ps
module sfs_bank_properties (
  input wire logic        clk_sys,
  input wire logic        rstn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [17:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  logic [17:0] ra;
  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn) ra <= 18'h0;
    else if (s_axi_arvalid && s_axi_arready) ra <= s_axi_araddr;
  localparam logic [17:0] A_CLEAR = {sfs_pkg::IDX_MEMORY_ECC_COUNTER_CLEAR, 2'h0};
  localparam logic [17:0] A_POWER_ON_SELF_TEST  = {sfs_pkg::IDX_POWER_ON_SELFTEST_STATUS, 2'h0};
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // ===========================================================
  // Handshake steps
  sequence s_wr_take; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
  sequence s_rd_take; s_axi_arvalid && s_axi_arready; endsequence
  a_write_answer: assert property (s_wr_take |-> ##2 s_axi_bvalid)
    else $error("write response not on time");
  a_read_answer: assert property (s_rd_take |=> s_axi_rvalid)
    else $error("read data not on time");
  a_wr_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_rd_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  a_bresp_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_rresp_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data repeated");
  a_slverr_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
    else $error("error read carries data");
  a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0)
    else $error("upper read bits not zero");
  a_clear_reads0: assert property (s_axi_rvalid && ra == A_CLEAR |-> s_axi_rdata == 32'h0)
    else $error("clear bits read back");
  a_pass_gated: assert property (s_axi_rvalid && ra == A_POWER_ON_SELF_TEST && !s_axi_rdata[7]
    |-> s_axi_rdata[6:5] == 2'h0) else $error("pass before done");
endmodule
bind sfs_bank sfs_bank_properties sfs_bank_properties_inst (.clk_sys(clk_sys), .rstn(rstn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

/* bench/tb.sv */
// Self-checking bench of the safety status bank
`timescale 1ns/100ps
module tb;
  logic                   clk_sys = 1'h0;
  logic                   rstn = 1'h0;
  sfs_pkg::sfs_events_t   ev = '0;
  sfs_pkg::sfs_selftest_t st = '0;
  logic                   step = 1'h0;
  logic [3:0]             strb = 4'hf;
  logic [17:0]            awaddr = 18'h0, araddr = 18'h0;
  logic [31:0]            wdata = 32'h0, rdata;
  logic                   awvalid = 1'h0, wvalid = 1'h0, arvalid = 1'h0;
  logic                   awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0]             bresp, rresp;
  logic [33:0]            exp_r[$], exp_b[$];
  logic [31:0]            seed = 32'hf2cf;
  logic [31:0]            flags = 32'h0;
  int                     errors = 0, n_checks = 0, i, wid[5];
  localparam logic [15:0] FL = sfs_pkg::IDX_SAFETY_ERROR_FLAGS;
  localparam logic [15:0] CL = sfs_pkg::IDX_MEMORY_ECC_COUNTER_CLEAR;
  localparam logic [15:0] ST = sfs_pkg::IDX_POWER_ON_SELFTEST_STATUS;
  localparam logic [15:0] IRS = sfs_pkg::IDX_IRQ_STATUS;
  localparam logic [15:0] UC = sfs_pkg::IDX_UNCORR_COUNT;
  localparam logic [15:0] CC = sfs_pkg::IDX_CORR_COUNT;
  localparam logic [15:0] RG[9] = '{FL, CL, ST, 16'h1d0b, 16'h1d0c, 16'h1d40, IRS, UC, CC};
  always #2.5 clk_sys = ~clk_sys;
  sfs_bank sfs_bank_inst (.clk_sys(clk_sys), .rstn(rstn), .events(ev), .msg_count_step(step),
    .selftest(st), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'h1), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(1'h1), .irq(irq));
  // ===========================================================
  // Helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  always @(posedge clk_sys) begin
    if (rvalid) chk("read", exp_r.pop_front(), {rresp, rdata});
    if (bvalid) chk("write", exp_b.pop_front(), {bresp, 32'h0});
  end
  task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] er);
    exp_b.push_back({er, 32'h0});
    awaddr <= {a, 2'h0};
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    do begin
      @(posedge clk_sys);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
    end while (!bvalid);
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] e, input logic [1:0] er);
    exp_r.push_back({er, e});
    araddr <= {a, 2'h0};
    arvalid <= 1'h1;
    do begin
      @(posedge clk_sys);
      if (arvalid && arready) arvalid <= 1'h0;
    end while (!rvalid);
  endtask
  task automatic pulse(input int b, input int w);
    ev[b] <= 1'h1;
    repeat (w) @(posedge clk_sys);
    ev[b] <= 1'h0;
    repeat (6) @(posedge clk_sys);
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #100000;
    errors++;
    finish_test();
  end
  // ===========================================================
  // Scenarios
  initial begin
    repeat (2) @(posedge clk_sys);
    rstn <= 1'h1;
    repeat (6) @(posedge clk_sys);
    foreach (RG[j]) rd(RG[j], 32'h0, 2'h0);
    for (i = 0; i < 5; i++) begin
      wid[i] = int'(rnd() % 4) + 1;
      pulse(i, wid[i]);
      flags[i == 0 ? 0 : i + 3] = 1'h1;
      rd(FL, flags, 2'h0);
    end
    chk("irq", 34'h0, 34'(irq));
    wr(FL, 32'hff, 2'h0);
    rd(FL, flags, 2'h0);
    rd(UC, 32'(wid[2]), 2'h0);
    rd(CC, 32'(wid[1]), 2'h0);
    wr(CL, 32'h0, 2'h0);
    rd(UC, 32'(wid[2]), 2'h0);
    wr(CL, 32'h2, 2'h0);
    rd(UC, 32'h0, 2'h0);
    rd(CC, 32'(wid[1]), 2'h0);
    wr(CL, 32'h1, 2'h0);
    rd(CC, 32'h0, 2'h0);
    wr(16'h1d40, 32'h10, 2'h0);
    repeat (3) @(posedge clk_sys);
    chk("irq", 34'h1, 34'(irq));
    wr(IRS, 32'h10, 2'h0);
    repeat (3) @(posedge clk_sys);
    chk("irq", 34'h0, 34'(irq));
    rd(IRS, flags & 32'hef, 2'h0);
    pulse(1, 1);
    chk("irq", 34'h1, 34'(irq));
    strb <= 4'h0;
    wr(CL, 32'h1, 2'h0);
    strb <= 4'hf;
    rd(CC, 32'h1, 2'h0);
    for (i = 0; i < 259; i++) begin
      step <= 1'h1;
      repeat (2) @(posedge clk_sys);
      step <= 1'h0;
      repeat (2) @(posedge clk_sys);
    end
    repeat (4) @(posedge clk_sys);
    rd(16'h1d0b, 32'h03, 2'h0);
    rd(16'h1d0c, 32'h01, 2'h0);
    st <= '{done: 1'h0, memory_passed: 1'h1, logic_passed: 1'h1};
    repeat (5) @(posedge clk_sys);
    rd(ST, 32'h0, 2'h0);
    st <= '{done: 1'h1, memory_passed: 1'h1, logic_passed: 1'h0};
    repeat (5) @(posedge clk_sys);
    rd(ST, 32'hc0, 2'h0);
    rd(16'h1d15, 32'h0, 2'h2);
    wr(16'h1d15, rnd(), 2'h2);
    repeat (4) @(posedge clk_sys);
    finish_test();
  end
endmodule

/* rtl/sfs_bank.sv */
// Safety fault status register bank with AXI4-Lite slave
`timescale 1ns/100ps
module sfs_bank (
  input  wire logic                  clk_sys,
  input  wire logic                  rstn,
  // Event, message and self-test inputs from the core, all resynchronised
  input  wire sfs_pkg::sfs_events_t  events,
  input  wire logic                  msg_count_step,
  input  wire sfs_pkg::sfs_selftest_t selftest,
  // Register port, write channels
  input  wire logic [sfs_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  // Register port, read channels
  input  wire logic [sfs_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // Level interrupt
  output logic                       irq
);

  // ===========================================================
  // Reset release
  logic       rst_q1;
  logic       rst_n;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rst_q1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n  <= rst_q1;
    end
  end

  // ===========================================================
  // Write channel capture
  logic [sfs_pkg::ADDR_W-1:0] aw_addr;
  logic                       aw_held;
  logic [31:0]                w_data;
  logic                       w_lane0;
  logic                       w_held;
  // Address and data may arrive in either order; each is held until the pair fires
  wire aw_take   = s_axi_awvalid && s_axi_awready;
  wire w_take    = s_axi_wvalid && s_axi_wready;
  wire wr_fire   = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (aw_take) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      w_held  <= 1'b0;
      w_data  <= '0;
      w_lane0 <= 1'b0;
    end else if (w_take) begin
      w_held  <= 1'b1;
      w_data  <= s_axi_wdata;
      w_lane0 <= s_axi_wstrb[0];
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held && !aw_take && !s_axi_bvalid;
      s_axi_wready  <= !w_held && !w_take && !s_axi_bvalid;
    end
  end

  // ===========================================================
  // Write decode
  wire [15:0] wr_idx     = 16'(aw_addr[sfs_pkg::ADDR_W-1:2]);
  wire        wr_clear   = wr_idx == sfs_pkg::IDX_MEMORY_ECC_COUNTER_CLEAR;
  wire        wr_mask    = wr_idx == sfs_pkg::IDX_IRQ_MASK;
  wire        wr_status  = wr_idx == sfs_pkg::IDX_IRQ_STATUS;
  wire        wr_ro      = wr_idx == sfs_pkg::IDX_SAFETY_ERROR_FLAGS
                        || wr_idx == sfs_pkg::IDX_POWER_ON_SELFTEST_STATUS
                        || wr_idx == sfs_pkg::IDX_CTRL_MSG_COUNT_LOW
                        || wr_idx == sfs_pkg::IDX_CTRL_MSG_COUNT_HIGH
                        || wr_idx == sfs_pkg::IDX_UNCORR_COUNT
                        || wr_idx == sfs_pkg::IDX_CORR_COUNT;
  wire        wr_hit     = wr_clear || wr_mask || wr_status || wr_ro;
  wire        wr_lo      = wr_fire && w_lane0;
  wire        clr_uncorr = wr_lo && wr_clear && w_data[sfs_pkg::BIT_CLR_UNCORR_CNT];
  wire        clr_corr   = wr_lo && wr_clear && w_data[sfs_pkg::BIT_CLR_CORR_CNT];

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= sfs_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? sfs_pkg::RESP_OKAY : sfs_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ===========================================================
  // Event synchronisers
  logic [4:0] ev_s1;
  logic [4:0] ev_s2;
  logic [2:0] st_s1;
  logic [2:0] st_s2;
  logic       step_s1;
  logic       step_s2;
  logic       step_d;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ev_s1 <= '0;
      ev_s2 <= '0;
    end else begin
      ev_s1 <= events;
      ev_s2 <= ev_s1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_s1 <= '0;
      st_s2 <= '0;
    end else begin
      st_s1 <= selftest;
      st_s2 <= st_s1;
    end
  end

  // Delayed copy resets low, the idle level of the pin, so no false edge
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      step_s1 <= 1'b0;
      step_s2 <= 1'b0;
      step_d  <= 1'b0;
    end else begin
      step_s1 <= msg_count_step;
      step_s2 <= step_s1;
      step_d  <= step_s2;
    end
  end
  sfs_pkg::sfs_events_t   ev;
  sfs_pkg::sfs_selftest_t st;
  assign ev = ev_s2;
  assign st = st_s2;

  // ===========================================================
  // Sticky flags
  logic [7:0] flags;
  wire  [7:0] flag_set;
  assign flag_set[sfs_pkg::BIT_MSG_COUNT_ERR] = ev.msg_count_mismatch;
  assign flag_set[sfs_pkg::BIT_CTRL_CRC_ERR]  = ev.ctrl_crc_mismatch;
  assign flag_set[sfs_pkg::BIT_UNCORR_ECC]    = ev.uncorr_ecc;
  assign flag_set[sfs_pkg::BIT_CORR_ECC]      = ev.corr_ecc;
  assign flag_set[3:1]                        = 3'h0;
  assign flag_set[sfs_pkg::BIT_REG_CRC_ERR]   = ev.reg_crc_error;

  // Flags clear only at reset; software sees them read-only
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) flags <= sfs_pkg::RST_FLAGS;
    else        flags <= flags | flag_set;
  end

  // ===========================================================
  // Interrupt status and mask, write one to clear, set wins
  logic [7:0] irq_status;
  logic [7:0] irq_mask;
  wire  [7:0] st_clr = (wr_lo && wr_status) ? w_data[7:0] : 8'h00;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) irq_status <= sfs_pkg::RST_FLAGS;
    else        irq_status <= (irq_status & ~st_clr) | flag_set;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)                irq_mask <= sfs_pkg::RST_MASK;
    else if (wr_lo && wr_mask) irq_mask <= w_data[7:0];
  end

  // Registered so the pin comes straight from a flop
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) irq <= 1'b0;
    else        irq <= |(irq_status & irq_mask);
  end

  // ===========================================================
  // ECC error counters, saturating
  logic [sfs_pkg::ECC_CNT_W-1:0] cnt_uncorr;
  logic [sfs_pkg::ECC_CNT_W-1:0] cnt_corr;
  logic [15:0]                   msg_count;
  localparam logic [sfs_pkg::ECC_CNT_W-1:0] CNT_ONE = (sfs_pkg::ECC_CNT_W)'(1);
  wire inc_uncorr = ev.uncorr_ecc && !(&cnt_uncorr);
  wire inc_corr   = ev.corr_ecc && !(&cnt_corr);

  // counter zeroing, clear wins over an increment
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)          cnt_uncorr <= '0;
    else if (clr_uncorr) cnt_uncorr <= '0;
    else if (inc_uncorr) cnt_uncorr <= cnt_uncorr + CNT_ONE;
  end

  // counter zeroing, clear wins over an increment
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)        cnt_corr <= '0;
    else if (clr_corr) cnt_corr <= '0;
    else if (inc_corr) cnt_corr <= cnt_corr + CNT_ONE;
  end

  // message counter advances per received message
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)                 msg_count <= '0;
    else if (step_s2 && !step_d) msg_count <= msg_count + 16'h0001;
  end

  // ===========================================================
  // Read path
  logic [7:0] power_on_self_test_status;
  always_comb begin
    power_on_self_test_status = 8'h00;
    power_on_self_test_status[sfs_pkg::BIT_SELFTEST_DONE] = st.done;
    power_on_self_test_status[sfs_pkg::BIT_MEM_ST_PASSED] = st.done && st.memory_passed;
    power_on_self_test_status[sfs_pkg::BIT_LOGIC_ST_PASS] = st.done && st.logic_passed;
  end

  wire [15:0] rd_idx = 16'(s_axi_araddr[sfs_pkg::ADDR_W-1:2]);
  logic [31:0] rd_val;
  logic        rd_hit;
  always_comb begin
    rd_hit = 1'b1;
    case (rd_idx)
      sfs_pkg::IDX_SAFETY_ERROR_FLAGS:       rd_val = {24'h0, flags};
      // Clear bits self-clear and always read 0
      sfs_pkg::IDX_MEMORY_ECC_COUNTER_CLEAR: rd_val = 32'h0;
      sfs_pkg::IDX_POWER_ON_SELFTEST_STATUS: rd_val = {24'h0, power_on_self_test_status};
      sfs_pkg::IDX_CTRL_MSG_COUNT_LOW:       rd_val = {24'h0, msg_count[7:0]};
      sfs_pkg::IDX_CTRL_MSG_COUNT_HIGH:      rd_val = {24'h0, msg_count[15:8]};
      sfs_pkg::IDX_IRQ_MASK:                 rd_val = {24'h0, irq_mask};
      sfs_pkg::IDX_IRQ_STATUS:               rd_val = {24'h0, irq_status};
      sfs_pkg::IDX_UNCORR_COUNT:             rd_val = {16'h0, cnt_uncorr};
      sfs_pkg::IDX_CORR_COUNT:               rd_val = {16'h0, cnt_corr};
      default: begin
        rd_val = 32'h0;
        rd_hit = 1'b0;
      end
    endcase
  end

  // Read data is captured in the cycle the address is taken
  wire ar_take = s_axi_arvalid && s_axi_arready;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= sfs_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !ar_take;
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_val;
        s_axi_rresp  <= rd_hit ? sfs_pkg::RESP_OKAY : sfs_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

/* rtl/sfs_pkg.sv */
// Package with register map, field positions, response codes and input types of the safety status bank
package sfs_pkg;

  // ===========================================================
  // Register indices (printed offsets) and address width
  localparam logic [15:0] IDX_SAFETY_ERROR_FLAGS        = 16'h1d13;
  localparam logic [15:0] IDX_MEMORY_ECC_COUNTER_CLEAR  = 16'h1d14;
  localparam logic [15:0] IDX_POWER_ON_SELFTEST_STATUS  = 16'h1d20;
  localparam logic [15:0] IDX_CTRL_MSG_COUNT_LOW        = 16'h1d0b;
  localparam logic [15:0] IDX_CTRL_MSG_COUNT_HIGH       = 16'h1d0c;
  localparam logic [15:0] IDX_IRQ_MASK                  = 16'h1d40;
  localparam logic [15:0] IDX_IRQ_STATUS                = 16'h1d41;
  localparam logic [15:0] IDX_UNCORR_COUNT              = 16'h1d42;
  localparam logic [15:0] IDX_CORR_COUNT                = 16'h1d43;
  localparam int          ADDR_W                        = 18;

  // ===========================================================
  // Field positions
  localparam int BIT_MSG_COUNT_ERR  = 7;
  localparam int BIT_CTRL_CRC_ERR   = 6;
  localparam int BIT_UNCORR_ECC     = 5;
  localparam int BIT_CORR_ECC       = 4;
  localparam int BIT_REG_CRC_ERR    = 0;
  localparam int BIT_CLR_UNCORR_CNT = 1;
  localparam int BIT_CLR_CORR_CNT   = 0;
  localparam int BIT_SELFTEST_DONE  = 7;
  localparam int BIT_MEM_ST_PASSED  = 6;
  localparam int BIT_LOGIC_ST_PASS  = 5;

  // ===========================================================
  // Reset values, widths and response codes
  localparam logic [7:0] RST_FLAGS   = 8'h00;
  localparam logic [7:0] RST_MASK    = 8'h00;
  localparam int         ECC_CNT_W   = 16;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ===========================================================
  // Event inputs from the surrounding logic
  typedef struct packed {
    logic msg_count_mismatch;
    logic ctrl_crc_mismatch;
    logic uncorr_ecc;
    logic corr_ecc;
    logic reg_crc_error;
  } sfs_events_t;

  // Self-test results from the power-on engine
  typedef struct packed {
    logic done;
    logic memory_passed;
    logic logic_passed;
  } sfs_selftest_t;

endpackage
